// file: design/smsb_cfg.svh
// Functional notes
// - Decode commanded mode bits into control mode
// - Host mode command updates commanded mode bits
// - Active mode outputs show mode in effect
// - Reference set request flags and updates reference
// - Flag reference set done after successful homing
// - Flag reference set error on homing failure
// - Flag zero reference re-creation request
// - Reflect host emergency stop on monitor bit
// - Alarm reset clears resettable alarms only
// - Torque-off state while motor energy cut
// - Each torque-off channel bit follows its channel
// - Input monitor bit is pin OR command
`ifndef SMSB_CFG_SVH
`define SMSB_CFG_SVH

// ****************************************
// Widths and reset values
// ****************************************
`define SMSB_REF_W 32
`define SMSB_REF_RST 32'h0000_0000
`define SMSB_ALM_W 8
`define SMSB_ALM_NONE 8'h00

`endif

// file: design/smsb_pkg.sv
package smsb_pkg;
    typedef enum logic [1:0] {
        SMSB_POS,
        SMSB_SPEED,
        SMSB_TLIM,
        SMSB_TCONT
    } smsb_mode_type;

    // Input monitor sources: pin side and host-command side
    typedef struct packed {
        logic mode_bit0;
        logic mode_bit1;
        logic torque_cont;
        logic ref_set_req;
        logic zero_ref_req;
        logic estop;
        logic alarm_reset;
        logic sto_ch1;
        logic sto_ch2;
    } smsb_din_type;

    typedef struct packed {
        logic act_mode_bit0;
        logic act_mode_bit1;
        logic act_torque_cont_bit;
        logic ref_set_done;
        logic ref_set_error;
        logic torque_off_state;
    } smsb_dout_type;
endpackage

// file: design/smsb_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pin inputs
module smsb_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire smsb_pkg::smsb_din_type d,
    output smsb_pkg::smsb_din_type q
);
    import smsb_pkg::*;

    smsb_din_type meta_reg;
    smsb_din_type meta_next;
    smsb_din_type q_reg;
    smsb_din_type q_next;

    // First stage is read only by the second stage
    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// file: design/smsb_top.sv
`timescale 1ns/1ps
`include "smsb_cfg.svh"
module smsb_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire smsb_pkg::smsb_din_type pin_in,
    input wire smsb_pkg::smsb_din_type host_cmd,
    input wire logic host_mode_cmd_valid,
    input wire logic [`SMSB_REF_W-1:0] ref_data_in,
    input wire logic homing_ok,
    input wire logic homing_fail,
    input wire logic sto_energy_cut,
    input wire logic alarm_raise,
    input wire logic [`SMSB_ALM_W-1:0] alarm_code,
    input wire logic alarm_no_reset,
    output smsb_pkg::smsb_din_type din_monitor,
    output smsb_pkg::smsb_dout_type dout,
    output logic [`SMSB_REF_W-1:0] ref_data,
    output logic [`SMSB_ALM_W-1:0] alarm_active,
    output logic alarm_latched
);
    import smsb_pkg::*;

    // ****************************************
    // Input conditioning
    // ****************************************
    smsb_din_type pin_sync;

    // Pins come from outside the clock domain
    smsb_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(pin_in),
        .q(pin_sync)
    );

    // Decode of the three mode bits; used once, on the monitor, to pick the control mode
    function automatic logic mode_decode(
        input logic b0,
        input logic b1,
        input logic b2,
        input smsb_mode_type prev,
        output smsb_mode_type m
    );
        logic ok;
        ok = 1'b1;
        m = prev;
        if (b2) begin
            m = SMSB_TCONT;
        end else begin
            unique case ({b1, b0})
                2'b00: m = SMSB_POS;
                2'b01: m = SMSB_SPEED;
                2'b10: m = SMSB_TLIM;
                2'b11: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    // ****************************************
    // Monitor and host command latch
    // ****************************************
    smsb_din_type mon_reg;
    smsb_din_type mon_next;
    smsb_din_type cmd_reg;
    smsb_din_type cmd_next;

    // Host level bits follow every cycle; mode bits wait for a command
    always_comb begin
        cmd_next = cmd_reg;
        if (host_mode_cmd_valid) begin
            cmd_next.mode_bit0 = host_cmd.mode_bit0;
            cmd_next.mode_bit1 = host_cmd.mode_bit1;
            cmd_next.torque_cont = host_cmd.torque_cont;
        end
        cmd_next.ref_set_req = host_cmd.ref_set_req;
        cmd_next.zero_ref_req = host_cmd.zero_ref_req;
        cmd_next.estop = host_cmd.estop;
        cmd_next.alarm_reset = host_cmd.alarm_reset;
        cmd_next.sto_ch1 = host_cmd.sto_ch1;
        cmd_next.sto_ch2 = host_cmd.sto_ch2;
        // Either source asserts the monitor bit
        mon_next = pin_sync | cmd_reg;
    end

    // Reset shows every monitored input as off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mon_reg <= '0;
            cmd_reg <= '0;
        end else begin
            mon_reg <= mon_next;
            cmd_reg <= cmd_next;
        end
    end

    // ****************************************
    // Control mode
    // ****************************************
    smsb_mode_type mode_reg;
    smsb_mode_type mode_next;

    // Decoded from the monitor, so pin and host share one mode
    always_comb begin
        smsb_mode_type dm;
        logic valid;
        dm = mode_reg;
        valid = 1'b0;
        valid = mode_decode(mon_reg.mode_bit0, mon_reg.mode_bit1,
                            mon_reg.torque_cont, mode_reg, dm);
        mode_next = valid ? dm : mode_reg;
    end

    // Position control is the quiet mode out of reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_reg <= SMSB_POS;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ****************************************
    // Status outputs and reference data
    // ****************************************
    smsb_dout_type dout_reg;
    smsb_dout_type dout_next;
    logic [`SMSB_REF_W-1:0] ref_reg;
    logic [`SMSB_REF_W-1:0] ref_next;

    // Homing results, active mode and torque-off state
    always_comb begin
        // Reference data follows source while request bit is on
        ref_next = mon_reg.ref_set_req ? ref_data_in : ref_reg;

        // Homing result flags; a new request clears the old result
        dout_next = dout_reg;
        if (mon_reg.ref_set_req) begin
            dout_next.ref_set_done = 1'b0;
            dout_next.ref_set_error = 1'b0;
        end
        if (homing_ok) begin
            dout_next.ref_set_done = 1'b1;
            dout_next.ref_set_error = 1'b0;
        end else if (homing_fail) begin
            dout_next.ref_set_error = 1'b1;
            dout_next.ref_set_done = 1'b0;
        end

        // Active mode status; first two bits are zero in torque-cont
        unique case (mode_reg)
            SMSB_POS: {dout_next.act_torque_cont_bit,
                       dout_next.act_mode_bit1,
                       dout_next.act_mode_bit0} = 3'h0;
            SMSB_SPEED: {dout_next.act_torque_cont_bit,
                         dout_next.act_mode_bit1,
                         dout_next.act_mode_bit0} = 3'h1;
            SMSB_TLIM: {dout_next.act_torque_cont_bit,
                        dout_next.act_mode_bit1,
                        dout_next.act_mode_bit0} = 3'h2;
            SMSB_TCONT: {dout_next.act_torque_cont_bit,
                         dout_next.act_mode_bit1,
                         dout_next.act_mode_bit0} = 3'h4;
        endcase

        dout_next.torque_off_state = sto_energy_cut;
    end

    // Status and reference registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dout_reg <= '0;
            ref_reg <= `SMSB_REF_RST;
        end else begin
            dout_reg <= dout_next;
            ref_reg <= ref_next;
        end
    end

    // ****************************************
    // Alarm hold and reset
    // ****************************************
    logic [`SMSB_ALM_W-1:0] alm_reg;
    logic [`SMSB_ALM_W-1:0] alm_next;
    logic keep_reg;
    logic keep_next;
    logic rst_prev_reg;
    logic rst_prev_next;

    // Reset acts on the rising edge of the monitor bit; a new
    // alarm in the same cycle wins over the reset
    always_comb begin
        rst_prev_next = mon_reg.alarm_reset;
        alm_next = alm_reg;
        keep_next = keep_reg;
        if (mon_reg.alarm_reset && !rst_prev_reg && !keep_reg) begin
            alm_next = `SMSB_ALM_NONE;
        end
        if (alarm_raise) begin
            alm_next = alarm_code;
            keep_next = alarm_no_reset;
        end
    end

    // Edge memory resets low, the idle level, so no false reset edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alm_reg <= `SMSB_ALM_NONE;
            keep_reg <= 1'b0;
            rst_prev_reg <= 1'b0;
        end else begin
            alm_reg <= alm_next;
            keep_reg <= keep_next;
            rst_prev_reg <= rst_prev_next;
        end
    end

    // ****************************************
    // Outputs, all from flip-flops
    // ****************************************
    assign din_monitor = mon_reg;
    assign dout = dout_reg;
    assign ref_data = ref_reg;
    assign alarm_active = alm_reg;
    assign alarm_latched = keep_reg;
endmodule

// file: verif/smsb_host.sv
`timescale 1ns/1ps
// ****
// Host command model
// ****
module smsb_host (
    input wire logic clk,
    input wire logic go,
    input wire logic [8:0] cmd,
    output smsb_pkg::smsb_din_type host_cmd,
    output logic host_mode_cmd_valid
);
    import smsb_pkg::*;
    initial host_cmd = '0;
    initial host_mode_cmd_valid = 1'b0;
    // Mode fields are junk unless valid, so a stale latch shows up
    always @(posedge clk) begin
        host_mode_cmd_valid <= #1 go;
        host_cmd <= #1 go ? cmd : {~cmd[8:6], cmd[5:0]};
    end
endmodule

// file: verif/smsb_assertions.sv
`timescale 1ns/1ps
`include "smsb_cfg.svh"
// ****
// Port checker
// ****
module smsb_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire smsb_pkg::smsb_din_type pin_in,
    input wire smsb_pkg::smsb_din_type host_cmd,
    input wire logic [`SMSB_REF_W-1:0] ref_data_in,
    input wire logic homing_ok,
    input wire logic homing_fail,
    input wire logic sto_energy_cut,
    input wire logic alarm_raise,
    input wire logic [`SMSB_ALM_W-1:0] alarm_code,
    input wire logic alarm_no_reset,
    input wire smsb_pkg::smsb_din_type din_monitor,
    input wire smsb_pkg::smsb_dout_type dout,
    input wire logic [`SMSB_REF_W-1:0] ref_data,
    input wire logic [`SMSB_ALM_W-1:0] alarm_active,
    input wire logic alarm_latched
);
    import smsb_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // First two active bits read 0 in torque-cont mode
    function automatic logic [2:0] mexp(logic [8:0] d);
        return d[6] ? 3'h1 : {d[8], d[7], 1'b0};
    endfunction
    sequence s_bad;
        din_monitor[8:6] == 3'h6;
    endsequence
    sequence s_good;
        din_monitor[8:6] != 3'h6;
    endsequence
    a_mode_decode: assert property (
        s_good |-> ##2 dout[5:3] == mexp($past(din_monitor, 2)))
        else $error("active mode wrong");
    a_mode_keep: assert property (
        s_bad |-> ##2 $stable(dout[5:3])) else $error("mode changed");
    a_monitor_or: assert property (
        din_monitor[5:0] == ($past(host_cmd[5:0], 2)
        | $past(pin_in[5:0], 3))) else $error("monitor bits wrong");
    a_torque_off: assert property (
        dout.torque_off_state == $past(sto_energy_cut))
        else $error("torque off wrong");
    a_done_flag: assert property (
        homing_ok && !din_monitor[5] |=> dout[2:1] == 2'h2)
        else $error("done wrong");
    a_error_flag: assert property (
        homing_fail && !homing_ok && !din_monitor[5] |=> dout[2:1] == 2'h1)
        else $error("error wrong");
    a_ref_load: assert property (
        din_monitor.ref_set_req |=> ref_data == $past(ref_data_in))
        else $error("ref not loaded");
    a_alarm_load: assert property (
        alarm_raise |=> alarm_active == $past(alarm_code)
        && alarm_latched == $past(alarm_no_reset)) else $error("alarm load");
    a_alarm_clear: assert property (
        $rose(din_monitor.alarm_reset) && !alarm_latched && !alarm_raise
        |=> alarm_active == 8'h00) else $error("alarm not cleared");
    a_alarm_keep: assert property (
        alarm_latched && !alarm_raise |=> $stable(alarm_active))
        else $error("latched alarm changed");
endmodule
bind smsb_top smsb_chk chk_u (.clk(clk), .sys_rst(sys_rst),
    .pin_in(pin_in), .host_cmd(host_cmd), .ref_data_in(ref_data_in),
    .homing_ok(homing_ok), .homing_fail(homing_fail),
    .sto_energy_cut(sto_energy_cut), .alarm_raise(alarm_raise),
    .alarm_code(alarm_code), .alarm_no_reset(alarm_no_reset),
    .din_monitor(din_monitor), .dout(dout), .ref_data(ref_data),
    .alarm_active(alarm_active), .alarm_latched(alarm_latched));

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    import smsb_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, go = 1'b0, hv, latched;
    logic ok = 1'b0, fail = 1'b0, cut = 1'b0, raise = 1'b0, nores = 1'b0;
    logic [8:0] cmd = '0;
    logic [7:0] code = '0, alm;
    logic [31:0] ref_in = '0, ref_data;
    smsb_din_type pin_in = '0, host_cmd, din_monitor;
    smsb_dout_type dout;
    int errors = 0, n_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    smsb_host host_u (.clk(clk), .go(go), .cmd(cmd), .host_cmd(host_cmd),
        .host_mode_cmd_valid(hv));
    smsb_top dut_u (.clk(clk), .sys_rst(sys_rst), .pin_in(pin_in),
        .host_cmd(host_cmd), .host_mode_cmd_valid(hv), .ref_data_in(ref_in),
        .homing_ok(ok), .homing_fail(fail), .sto_energy_cut(cut),
        .alarm_raise(raise), .alarm_code(code), .alarm_no_reset(nores),
        .din_monitor(din_monitor), .dout(dout), .ref_data(ref_data),
        .alarm_active(alm), .alarm_latched(latched));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(string s, logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Every listed mode, with the unlisted code 6 between them, which must be ignored
    task automatic t_mode();
        logic [2:0] m [8] = '{3'h0, 3'h4, 3'h6, 3'h2, 3'h6, 3'h1, 3'h7, 3'h6};
        logic [2:0] e [8] = '{3'h0, 3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1};
        for (int i = 0; i < 8; i++) begin
            cmd[8:6] = m[i];
            go = 1'b1;
            step(1);
            go = 1'b0;
            step(6);
            chk("mode_mon", din_monitor[8:6], m[i]);
            chk("act_mode", dout[5:3], e[i]);
        end
        // Host back to position; a pin mode bit alone selects torque limit
        cmd[8:6] = 3'h0;
        go = 1'b1;
        step(1);
        go = 1'b0;
        pin_in.mode_bit1 = 1'b1;
        step(8);
        chk("mode_pin", din_monitor[8:6], 3'h2);
        chk("act_pin", dout[5:3], 3'h2);
        pin_in = '0;
        step(8);
        chk("act_pos", dout[5:3], 3'h0);
    endtask
    // Each of the six level monitor bits from the pin alone, the host alone, then neither
    task automatic t_mon();
        for (int i = 0; i < 6; i++) begin
            pin_in[5:0] = 6'h1 << i;
            step(5);
            chk("mon_pin", din_monitor[5:0], 6'h1 << i);
            pin_in = '0;
            cmd[5:0] = 6'h1 << i;
            step(5);
            chk("mon_host", din_monitor[5:0], 6'h1 << i);
            cmd[5:0] = '0;
            step(5);
            chk("mon_off", din_monitor[5:0], 6'h0);
        end
    endtask
    task automatic t_ref();
        ref_in = 32'h1234_5678;
        cmd[5] = 1'b1;
        step(5);
        chk("ref_load", ref_data, 32'h1234_5678);
        cmd[5] = 1'b0;
        step(5);
        ref_in = 32'h0bad_cafe;
        step(3);
        chk("ref_hold", ref_data, 32'h1234_5678);
        ok = 1'b1;
        step(1);
        ok = 1'b0;
        step(1);
        chk("done", dout[2:1], 2'h2);
        fail = 1'b1;
        step(1);
        fail = 1'b0;
        step(1);
        chk("error", dout[2:1], 2'h1);
    endtask
    // A resettable alarm clears, a latched one survives the reset bit
    task automatic t_sto_alarm();
        cut = 1'b1;
        step(2);
        chk("sto", dout[0], 1'b1);
        for (int i = 0; i < 2; i++) begin
            cut = 1'b0;
            nores = i[0];
            code = 8'h5a;
            raise = 1'b1;
            step(1);
            raise = 1'b0;
            cmd[2] = 1'b1;
            step(5);
            cmd[2] = 1'b0;
            chk("alarm", alm, i ? 8'h5a : 8'h00);
            chk("latched", latched, i);
            step(3);
        end
        chk("sto_off", dout[0], 1'b0);
    endtask
    initial begin
        step(10);
        sys_rst = 1'b0;
        step(1);
        t_mode();
        t_mon();
        t_ref();
        t_sto_alarm();
        summarize();
    end
    // Watchdog; the whole sequence needs well under 400 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            summarize();
        end
    end
endmodule
